// File: logic/scp_pkg.sv
package scp_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD_9600 = 9600;
    localparam int BAUD_19200 = 19200;
    localparam int BAUD_38400 = 38400;
    localparam int BAUD_115200 = 115200;
    // cycles per bit, rounded down
    localparam logic [15:0] DIV_9600 = 16'(CLK_HZ / BAUD_9600);
    localparam logic [15:0] DIV_19200 = 16'(CLK_HZ / BAUD_19200);
    localparam logic [15:0] DIV_38400 = 16'(CLK_HZ / BAUD_38400);
    localparam logic [15:0] DIV_115200 = 16'(CLK_HZ / BAUD_115200);
    localparam logic [1:0] BAUD_IDX_9600 = 2'h0;
    localparam logic [1:0] BAUD_IDX_19200 = 2'h1;
    localparam logic [1:0] BAUD_IDX_38400 = 2'h2;
    localparam logic [1:0] BAUD_IDX_115200 = 2'h3;
    localparam int FIFO_DEPTH = 512;
    localparam int DATA_W = 8;
    localparam int CNT_W = 10;
    localparam logic [9:0] STALL_LEVEL = 10'(FIFO_DEPTH - 2);
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] DEST_MAIN = 2'h1;
    localparam logic [1:0] DEST_AUX = 2'h2;
    localparam logic [1:0] MARK_ON = 2'h1;
    localparam logic [1:0] MARK_OFF = 2'h2;
    localparam logic FULL_DROP = 1'h1;
    localparam logic [7:0] CHAR_COLON = 8'h3A;
    localparam logic [7:0] CHAR_QMARK = 8'h3F;
    localparam logic [7:0] HIGH_BIT = 8'h80;
    localparam logic DFLT_RST = 1'h0;
    localparam logic MARK_RST = 1'h0;
    localparam logic DROP_RST = 1'h0;

    typedef struct packed {
        logic [1:0] baud;
        logic handshake;
        logic mode;
        logic echo;
    } scp_aux_cfg_type;

    localparam scp_aux_cfg_type AUX_CFG_RST = '{BAUD_IDX_9600, 1'h0, 1'h0, 1'h0};

    typedef struct packed {
        logic [1:0] mark_arg;
        logic full_wr;
        logic full_arg;
    } scp_fmt_type;

    typedef struct packed {
        logic [7:0] data;
        logic [1:0] dest;
    } scp_msg_type;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} scp_tx_state_type;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} scp_rx_state_type;
endpackage

// File: logic/scp_port.sv
// Notes on behaviour
// - while a program runs, messages and command errors produce unprompted output
// - unprompted output without destination goes to default port, main after reset
// - marking argument 1 sets bit 7 of unprompted characters, 2 stops it
// - outgoing characters pass through a 512-byte first-in first-out buffer
// - full policy 1 drops new messages when full (replies and echoes wait), 0 stalls command execution
// - frames are start, eight data bits, no parity, one stop; full duplex
// - main bit rate follows the two jumpers: 9600, 19200, 38400, 115200
// - main port clear-to-send goes high while reception cannot be accepted
// - request-to-send high from the host holds off further transmission
// - on the auxiliary port the two handshake lines swap roles
// - auxiliary configuration picks 9600, 19200, 38400 or 115200
// - auxiliary handshake field: 0 off, 1 on
// - auxiliary mode field: 0 withholds received characters from rx_valid_o, 1 delivers them
// - auxiliary echo field turns echo off or on, only while mode is 0
// - outside a program each decoded command answers colon or question mark on its port
`timescale 1ns/1ns
module scp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 512
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        in_ready_o = cnt_q != (AW+1)'(DEPTH);
        out_valid_o = cnt_q != '0;
        out_data_o = mem_q[rd_q];
        count_o = cnt_q;
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wr_d = push ? wr_q + 1'h1 : wr_q;
        rd_d = pop ? rd_q + 1'h1 : rd_q;
        cnt_d = cnt_q + {{AW{1'h0}}, push} - {{AW{1'h0}}, pop};
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage carries no reset so it maps onto block memory
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end
endmodule

module scp_port (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [1:0] baud_select_jumper_i,
    input wire logic main_rxd_i,
    output logic main_txd_o,
    output logic main_cts_o,
    input wire logic main_rts_i,
    input wire logic aux_rxd_i,
    output logic aux_txd_o,
    output logic aux_rts_o,
    input wire logic aux_cts_i,
    input wire logic aux_cfg_wr_i,
    input wire scp_pkg::scp_aux_cfg_type aux_cfg_i,
    input wire logic fmt_wr_i,
    input wire scp_pkg::scp_fmt_type fmt_i,
    input wire logic dflt_wr_i,
    input wire logic dflt_port_i,
    input wire logic prog_run_i,
    input wire logic msg_valid_i,
    input wire scp_pkg::scp_msg_type msg_i,
    input wire logic cmd_done_i,
    input wire logic cmd_ok_i,
    input wire logic cmd_port_i,
    input wire logic [1:0] rx_busy_i,
    output logic [1:0] rx_valid_o,
    output logic [15:0] rx_data_o,
    output logic exec_stall_o,
    output logic [1:0] fifo_full_o
);
    logic dflt_q, dflt_d, mark_q, mark_d, drop_q, drop_d, stall_q, stall_d;
    logic cts_q, cts_d, rts_q, rts_d;
    logic [1:0] full_q, full_d;
    scp_pkg::scp_aux_cfg_type cfg_q, cfg_d;
    logic msg_take, msg_port, rep_need, rep_port;
    logic [7:0] msg_byte, rep_byte;
    logic [1:0] rxd_w, inh_w, hs_w, dlv_w, echo_w, ready_w;
    logic [15:0] div_w [2];
    logic [scp_pkg::CNT_W-1:0] cnt_w [2];

    function automatic logic [15:0] div_of(input logic [1:0] idx);
        case (idx)
            scp_pkg::BAUD_IDX_9600: div_of = scp_pkg::DIV_9600;
            scp_pkg::BAUD_IDX_19200: div_of = scp_pkg::DIV_19200;
            scp_pkg::BAUD_IDX_38400: div_of = scp_pkg::DIV_38400;
            default: div_of = scp_pkg::DIV_115200;
        endcase
    endfunction

    always_comb begin
        // jumper on reads 1; both on is the slowest rate
        div_w[0] = div_of(~baud_select_jumper_i);
        div_w[1] = div_of(cfg_q.baud);
        rxd_w = {aux_rxd_i, main_rxd_i};
        inh_w = {aux_cts_i, main_rts_i};
        hs_w = {cfg_q.handshake, 1'h1};
        dlv_w = {cfg_q.mode, 1'h1};
        echo_w = {!cfg_q.mode && cfg_q.echo, 1'h0};
        dflt_d = dflt_wr_i ? dflt_port_i : dflt_q;
        mark_d = mark_q;
        drop_d = drop_q;
        if (fmt_wr_i && fmt_i.mark_arg == scp_pkg::MARK_ON) begin
            mark_d = 1'h1;
        end else if (fmt_wr_i && fmt_i.mark_arg == scp_pkg::MARK_OFF) begin
            mark_d = 1'h0;
        end
        if (fmt_wr_i && fmt_i.full_wr) begin
            drop_d = fmt_i.full_arg;
        end
        cfg_d = aux_cfg_wr_i ? aux_cfg_i : cfg_q;
        msg_take = msg_valid_i && !stall_q;
        if (msg_i.dest == scp_pkg::DEST_MAIN) begin
            msg_port = 1'h0;
        end else if (msg_i.dest == scp_pkg::DEST_AUX) begin
            msg_port = 1'h1;
        end else begin
            msg_port = dflt_q;
        end
        msg_byte = msg_i.data;
        if (prog_run_i && mark_q) begin
            msg_byte = msg_i.data | scp_pkg::HIGH_BIT;
        end
        // in a program only errors speak, unprompted, to the default port
        rep_need = cmd_done_i && (!prog_run_i || !cmd_ok_i);
        rep_port = prog_run_i ? dflt_q : cmd_port_i;
        rep_byte = cmd_ok_i ? scp_pkg::CHAR_COLON : scp_pkg::CHAR_QMARK;
        if (prog_run_i && mark_q) begin
            rep_byte = rep_byte | scp_pkg::HIGH_BIT;
        end
        // two below full leaves room for the message taken while stall rises
        stall_d = drop_q != scp_pkg::FULL_DROP &&
            (cnt_w[0] >= scp_pkg::STALL_LEVEL || cnt_w[1] >= scp_pkg::STALL_LEVEL);
        cts_d = rx_busy_i[0];
        rts_d = cfg_q.handshake && rx_busy_i[1];
        full_d = ~ready_w;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dflt_q <= scp_pkg::DFLT_RST;
            mark_q <= scp_pkg::MARK_RST;
            drop_q <= scp_pkg::DROP_RST;
            cfg_q <= scp_pkg::AUX_CFG_RST;
            stall_q <= 1'h0;
            cts_q <= 1'h0;
            rts_q <= 1'h0;
            full_q <= 2'h0;
        end else begin
            dflt_q <= dflt_d;
            mark_q <= mark_d;
            drop_q <= drop_d;
            cfg_q <= cfg_d;
            stall_q <= stall_d;
            cts_q <= cts_d;
            rts_q <= rts_d;
            full_q <= full_d;
        end
    end

    assign exec_stall_o = stall_q;
    assign main_cts_o = cts_q;
    assign aux_rts_o = rts_q;
    assign fifo_full_o = full_q;

    for (genvar p = 0; p < 2; p++) begin : g_port
        logic pv_q, pv_d, ev_q, ev_d, push_v, pop, txd_q, txd_d, rv_q, rv_d, ov_q, ov_d;
        logic [7:0] pdat_q, pdat_d, edat_q, edat_d, push_data, out_data;
        logic [7:0] tsh_q, tsh_d, rsh_q, rsh_d, rdat_q, rdat_d;
        logic [15:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
        logic [2:0] tbit_q, tbit_d, rbit_q, rbit_d;
        logic out_valid, done;
        scp_pkg::scp_tx_state_type tst_q, tst_d;
        scp_pkg::scp_rx_state_type rst_q, rst_d;

        scp_fifo #(.W(scp_pkg::DATA_W), .DEPTH(scp_pkg::FIFO_DEPTH)) u_fifo (
            .clk_i(sys_clk_i),
            .rst_b_i(rst_b_i),
            .in_valid_i(push_v),
            .in_data_i(push_data),
            .in_ready_o(ready_w[p]),
            .out_valid_o(out_valid),
            .out_data_o(out_data),
            .out_ready_i(pop),
            .count_o(cnt_w[p])
        );

        always_comb begin
            pv_d = pv_q;
            pdat_d = pdat_q;
            ev_d = ev_q;
            edat_d = edat_q;
            push_v = 1'h0;
            push_data = pdat_q;
            // in drop mode a message meeting a full buffer is simply lost
            if (msg_take && msg_port == 1'(p)) begin
                push_v = 1'h1;
                push_data = msg_byte;
            end else if (pv_q) begin
                push_v = 1'h1;
                pv_d = !ready_w[p];
            end else if (ev_q) begin
                push_v = 1'h1;
                push_data = edat_q;
                ev_d = !ready_w[p];
            end
            if (rep_need && rep_port == 1'(p)) begin
                pv_d = 1'h1;
                pdat_d = rep_byte;
            end
            if (rv_q && echo_w[p]) begin
                ev_d = 1'h1;
                edat_d = rdat_q;
            end
        end

        always_comb begin
            tst_d = tst_q;
            tcnt_d = tcnt_q - 16'h1;
            tbit_d = tbit_q;
            tsh_d = tsh_q;
            txd_d = txd_q;
            pop = 1'h0;
            case (tst_q)
                scp_pkg::TX_IDLE: begin
                    txd_d = 1'h1;
                    if (out_valid && !(hs_w[p] && inh_w[p])) begin
                        pop = 1'h1;
                        tsh_d = out_data;
                        tcnt_d = div_w[p] - 16'h1;
                        tst_d = scp_pkg::TX_START;
                        txd_d = 1'h0;
                    end
                end
                scp_pkg::TX_START: begin
                    if (tcnt_q == 16'h0) begin
                        tst_d = scp_pkg::TX_DATA;
                        tcnt_d = div_w[p] - 16'h1;
                        tbit_d = 3'h0;
                        txd_d = tsh_q[0];
                    end
                end
                scp_pkg::TX_DATA: begin
                    if (tcnt_q == 16'h0) begin
                        tcnt_d = div_w[p] - 16'h1;
                        tsh_d = {1'h0, tsh_q[7:1]};
                        txd_d = tsh_q[1];
                        tbit_d = tbit_q + 3'h1;
                        if (tbit_q == scp_pkg::LAST_BIT) begin
                            tst_d = scp_pkg::TX_STOP;
                            txd_d = 1'h1;
                        end
                    end
                end
                scp_pkg::TX_STOP: begin
                    if (tcnt_q == 16'h0) begin
                        tst_d = scp_pkg::TX_IDLE;
                    end
                end
                default: tst_d = scp_pkg::TX_IDLE;
            endcase
        end

        // receiver samples mid-bit; a bad stop bit drops the character
        always_comb begin
            rst_d = rst_q;
            rcnt_d = rcnt_q - 16'h1;
            rbit_d = rbit_q;
            rsh_d = rsh_q;
            rdat_d = rdat_q;
            done = 1'h0;
            case (rst_q)
                scp_pkg::RX_IDLE: begin
                    if (!rxd_w[p]) begin
                        rst_d = scp_pkg::RX_START;
                        rcnt_d = {1'h0, div_w[p][15:1]};
                    end
                end
                scp_pkg::RX_START: begin
                    if (rcnt_q == 16'h0) begin
                        rst_d = rxd_w[p] ? scp_pkg::RX_IDLE : scp_pkg::RX_DATA;
                        rcnt_d = div_w[p] - 16'h1;
                        rbit_d = 3'h0;
                    end
                end
                scp_pkg::RX_DATA: begin
                    if (rcnt_q == 16'h0) begin
                        rsh_d = {rxd_w[p], rsh_q[7:1]};
                        rcnt_d = div_w[p] - 16'h1;
                        rbit_d = rbit_q + 3'h1;
                        if (rbit_q == scp_pkg::LAST_BIT) begin
                            rst_d = scp_pkg::RX_STOP;
                        end
                    end
                end
                scp_pkg::RX_STOP: begin
                    if (rcnt_q == 16'h0) begin
                        rst_d = scp_pkg::RX_IDLE;
                        done = rxd_w[p];
                        rdat_d = done ? rsh_q : rdat_q;
                    end
                end
                default: rst_d = scp_pkg::RX_IDLE;
            endcase
            rv_d = done;
            // delivery gated before the flop so the output pin is a plain register
            ov_d = done && dlv_w[p];
        end

        always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                pv_q <= 1'h0;
                pdat_q <= 8'h0;
                ev_q <= 1'h0;
                edat_q <= 8'h0;
                tst_q <= scp_pkg::TX_IDLE;
                tcnt_q <= 16'h0;
                tbit_q <= 3'h0;
                tsh_q <= 8'h0;
                txd_q <= 1'h1;
                rst_q <= scp_pkg::RX_IDLE;
                rcnt_q <= 16'h0;
                rbit_q <= 3'h0;
                rsh_q <= 8'h0;
                rdat_q <= 8'h0;
                rv_q <= 1'h0;
                ov_q <= 1'h0;
            end else begin
                pv_q <= pv_d;
                pdat_q <= pdat_d;
                ev_q <= ev_d;
                edat_q <= edat_d;
                tst_q <= tst_d;
                tcnt_q <= tcnt_d;
                tbit_q <= tbit_d;
                tsh_q <= tsh_d;
                txd_q <= txd_d;
                rst_q <= rst_d;
                rcnt_q <= rcnt_d;
                rbit_q <= rbit_d;
                rsh_q <= rsh_d;
                rdat_q <= rdat_d;
                rv_q <= rv_d;
                ov_q <= ov_d;
            end
        end

        assign rx_valid_o[p] = ov_q;
        assign rx_data_o[p*8 +: 8] = rdat_q;
    end

    assign main_txd_o = g_port[0].txd_q;
    assign aux_txd_o = g_port[1].txd_q;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_main_rate;
        baud_select_jumper_i == 2'h3 |-> div_w[0] == scp_pkg::DIV_9600;
    endproperty
    a_main_rate: assert property (p_main_rate) else $error("main rate wrong");
    property p_cts;
        rx_busy_i[0] |=> main_cts_o;
    endproperty
    a_cts: assert property (p_cts) else $error("cts not raised");
    property p_main_inhibit;
        (g_port[0].tst_q == scp_pkg::TX_IDLE ##1 g_port[0].tst_q == scp_pkg::TX_START)
            |-> !$past(main_rts_i);
    endproperty
    a_main_inhibit: assert property (p_main_inhibit) else $error("sent while held off");
    property p_aux_inhibit;
        (g_port[1].tst_q == scp_pkg::TX_IDLE ##1 g_port[1].tst_q == scp_pkg::TX_START)
            |-> !$past(aux_cts_i && cfg_q.handshake);
    endproperty
    a_aux_inhibit: assert property (p_aux_inhibit) else $error("aux sent while held");
    property p_start_bit;
        g_port[0].tst_q == scp_pkg::TX_START |-> !main_txd_o;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit not low");
    property p_stop_bit;
        g_port[0].tst_q == scp_pkg::TX_STOP |-> main_txd_o;
    endproperty
    a_stop_bit: assert property (p_stop_bit) else $error("stop bit not high");
    property p_mark;
        msg_take && prog_run_i && mark_q && msg_i.dest == scp_pkg::DEST_MAIN
            |-> g_port[0].push_v && g_port[0].push_data[7];
    endproperty
    a_mark: assert property (p_mark) else $error("high bit not set");
    property p_dflt;
        msg_take && msg_i.dest == 2'h0 && !dflt_q |-> g_port[0].push_v;
    endproperty
    a_dflt: assert property (p_dflt) else $error("default route wrong");
    property p_stall;
        drop_q != scp_pkg::FULL_DROP && cnt_w[0] >= scp_pkg::STALL_LEVEL |=> exec_stall_o;
    endproperty
    a_stall: assert property (p_stall) else $error("no stall when full");
    property p_reply;
        cmd_done_i && cmd_ok_i && !prog_run_i && !cmd_port_i
            |=> g_port[0].pv_q && g_port[0].pdat_q == scp_pkg::CHAR_COLON;
    endproperty
    a_reply: assert property (p_reply) else $error("colon not queued");
    property p_echo;
        g_port[1].rv_q && !cfg_q.mode && cfg_q.echo |=> g_port[1].ev_q;
    endproperty
    a_echo: assert property (p_echo) else $error("echo not queued");

    c_main_tx: cover property (g_port[0].tst_q == scp_pkg::TX_STOP ##1
        g_port[0].tst_q == scp_pkg::TX_IDLE);
    c_full: cover property (fifo_full_o[0]);
    c_stall: cover property (exec_stall_o);
    c_echo: cover property (g_port[1].ev_q);
endmodule

// File: sim/scp_host.sv
`timescale 1ns/1ns
module scp_host (
    input wire logic clk_i,
    input wire logic [15:0] div_i,
    input wire logic txd_i,
    output logic rxd_o,
    output logic got_o,
    output logic [8:0] byte_o
);
    initial begin
        rxd_o = 1'h1;
        got_o = 1'h0;
        byte_o = 9'h000;
    end
    // mid-bit sampling; byte_o[8] carries the stop bit so a bad frame shows up
    always begin
        @(negedge txd_i);
        repeat (div_i / 2) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (div_i) @(posedge clk_i);
            byte_o[i] = txd_i;
        end
        got_o = 1'h1;
        @(posedge clk_i);
        got_o = 1'h0;
    end
    // line idles high between frames
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            rxd_o <= (i == 0) ? 1'h0 : (i == 9) ? 1'h1 : b[i-1];
            repeat (div_i) @(negedge clk_i);
        end
    endtask
endmodule

// File: sim/scp_port_tb_top.sv
`timescale 1ns/1ns
module scp_port_tb_top;
    logic sys_clk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic [1:0] jmp = 2'h3;
    logic main_rts = 1'h0;
    logic aux_cts = 1'h0;
    logic aux_cfg_wr = 1'h0;
    scp_pkg::scp_aux_cfg_type aux_cfg = scp_pkg::AUX_CFG_RST;
    logic fmt_wr = 1'h0;
    scp_pkg::scp_fmt_type fmt = '0;
    logic dflt_wr = 1'h0;
    logic dflt_port = 1'h0;
    logic prog_run = 1'h0;
    logic msg_valid = 1'h0;
    scp_pkg::scp_msg_type msg = '0;
    logic cmd_done = 1'h0;
    logic cmd_ok = 1'h0;
    logic cmd_port = 1'h0;
    logic [1:0] rx_busy = 2'h0;
    logic main_txd, main_cts, aux_txd, aux_rts, stall, main_rxd, aux_rxd, main_got, aux_got;
    logic [1:0] rx_valid, fifo_full;
    logic [15:0] rx_data;
    logic [8:0] main_byte, aux_byte;
    logic [15:0] divs [4] = '{scp_pkg::DIV_9600, scp_pkg::DIV_19200,
        scp_pkg::DIV_38400, scp_pkg::DIV_115200};
    logic [1:0] marks [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    logic [15:0] main_div = scp_pkg::DIV_9600;
    logic [15:0] aux_div = scp_pkg::DIV_115200;
    logic [7:0] exp_main[$], exp_aux[$];
    logic [8:0] exp_rx[$];
    int n_fail = 0;
    int compares = 0;
    int k;
    logic [7:0] b;

    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    scp_port scp_port_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .baud_select_jumper_i(jmp), .main_rxd_i(main_rxd), .main_txd_o(main_txd),
        .main_cts_o(main_cts), .main_rts_i(main_rts), .aux_rxd_i(aux_rxd),
        .aux_txd_o(aux_txd), .aux_rts_o(aux_rts), .aux_cts_i(aux_cts),
        .aux_cfg_wr_i(aux_cfg_wr), .aux_cfg_i(aux_cfg), .fmt_wr_i(fmt_wr), .fmt_i(fmt),
        .dflt_wr_i(dflt_wr), .dflt_port_i(dflt_port), .prog_run_i(prog_run),
        .msg_valid_i(msg_valid), .msg_i(msg), .cmd_done_i(cmd_done), .cmd_ok_i(cmd_ok),
        .cmd_port_i(cmd_port), .rx_busy_i(rx_busy), .rx_valid_o(rx_valid),
        .rx_data_o(rx_data), .exec_stall_o(stall), .fifo_full_o(fifo_full));
    scp_host host_main (.clk_i(sys_clk_i), .div_i(main_div), .txd_i(main_txd),
        .rxd_o(main_rxd), .got_o(main_got), .byte_o(main_byte));
    scp_host host_aux (.clk_i(sys_clk_i), .div_i(aux_div), .txd_i(aux_txd),
        .rxd_o(aux_rxd), .got_o(aux_got), .byte_o(aux_byte));

    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        compares++;
        if (seen !== expv) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic print_verdict();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // results arrive in order, so the oldest note is the one to compare
    always @(posedge main_got) begin
        check(16'(main_byte), exp_main.size() > 0 ? 16'({1'h1, exp_main.pop_front()}) : 16'hFFFF);
    end
    always @(posedge aux_got) begin
        check(16'(aux_byte), exp_aux.size() > 0 ? 16'({1'h1, exp_aux.pop_front()}) : 16'hFFFF);
    end
    always @(negedge sys_clk_i) begin
        for (int p = 0; p < 2; p++) begin
            if (rx_valid[p] === 1'h1) begin
                check(16'({p[0], rx_data[p*8 +: 8]}),
                    exp_rx.size() > 0 ? 16'(exp_rx.pop_front()) : 16'hFFFF);
            end
        end
    end

    task automatic pulse(ref logic s);
        @(negedge sys_clk_i);
        s = 1'h1;
        @(negedge sys_clk_i);
        s = 1'h0;
    endtask

    task automatic put(input logic [7:0] d, input logic [1:0] dest);
        msg = {d, dest};
        pulse(msg_valid);
    endtask

    task automatic cmd(input logic run, input logic ok, input logic port);
        prog_run = run;
        cmd_ok = ok;
        cmd_port = port;
        pulse(cmd_done);
    endtask

    task automatic set_aux(input logic hs, input logic mode, input logic echo);
        aux_cfg = {2'h3, hs, mode, echo};
        pulse(aux_cfg_wr);
    endtask

    task automatic wait_idle();
        k = 0;
        while ((exp_main.size() + exp_aux.size() + exp_rx.size()) > 0) begin
            @(negedge sys_clk_i);
            k++;
            if (k > 40000) begin
                n_fail++;
                print_verdict();
            end
        end
        repeat (20) @(negedge sys_clk_i);
    endtask

    task automatic do_reset();
        rst_b_i = 1'h0;
        repeat (10) @(negedge sys_clk_i);
        rst_b_i = 1'h1;
    endtask

    initial begin
        void'($urandom(32'hFBA45BA5));
        do_reset();
        check(16'({main_txd, aux_txd, main_cts, aux_rts, stall, fifo_full}), 16'h0060);
        for (int j = 0; j < 4; j++) begin
            jmp = 2'(3 - j);
            main_div = divs[j];
            b = 8'($urandom);
            exp_main.push_back(b);
            exp_main.push_back(~b);
            exp_aux.push_back(b);
            aux_cfg = {2'(j), 3'h0};
            aux_div = divs[j];
            pulse(aux_cfg_wr);
            put(b, 2'h0);
            put(~b, 2'h3);
            put(b, 2'h2);
            wait_idle();
        end
        $display("baud test done");
        set_aux(1'h0, 1'h1, 1'h0);
        prog_run = 1'h1;
        for (int j = 0; j < 4; j++) begin
            fmt = {marks[j], 2'h0};
            pulse(fmt_wr);
            b = 8'($urandom) & 8'h7F;
            exp_main.push_back(b | ((j < 2) ? scp_pkg::HIGH_BIT : 8'h00));
            put(b, 2'h1);
            wait_idle();
        end
        $display("marking test done");
        // handshake off: a high aux_cts_i must not hold the aux replies back
        aux_cts = 1'h1;
        exp_main.push_back(scp_pkg::CHAR_COLON);
        cmd(1'h0, 1'h1, 1'h0);
        exp_aux.push_back(scp_pkg::CHAR_QMARK);
        cmd(1'h0, 1'h0, 1'h1);
        cmd(1'h1, 1'h1, 1'h1);
        exp_main.push_back(scp_pkg::CHAR_QMARK);
        cmd(1'h1, 1'h0, 1'h1);
        wait_idle();
        dflt_port = 1'h1;
        pulse(dflt_wr);
        exp_aux.push_back(scp_pkg::CHAR_QMARK);
        cmd(1'h1, 1'h0, 1'h0);
        wait_idle();
        b = 8'($urandom) & 8'h7F;
        exp_aux.push_back(b);
        put(b, 2'h0);
        wait_idle();
        aux_cts = 1'h0;
        $display("reply test done");
        set_aux(1'h1, 1'h1, 1'h0);
        for (int p = 0; p < 2; p++) begin
            main_rts = (p == 0);
            aux_cts = (p == 1);
            b = 8'($urandom);
            put(b, 2'(p + 1));
            k = 0;
            repeat (300) begin
                @(negedge sys_clk_i);
                if ((p ? aux_txd : main_txd) !== 1'h1) k++;
            end
            check(16'(k), 16'h0000);
            if (p == 1) exp_aux.push_back(b);
            else exp_main.push_back(b);
            main_rts = 1'h0;
            aux_cts = 1'h0;
            wait_idle();
        end
        for (int h = 0; h < 2; h++) begin
            set_aux(h[0], 1'h1, 1'h0);
            rx_busy = 2'h3;
            @(negedge sys_clk_i);
            check(16'({main_cts, aux_rts}), 16'({1'h1, h[0]}));
            rx_busy = 2'h0;
            @(negedge sys_clk_i);
            check(16'({main_cts, aux_rts}), 16'h0000);
        end
        $display("handshake test done");
        b = 8'($urandom);
        exp_rx.push_back({1'h0, b});
        exp_rx.push_back({1'h1, ~b});
        exp_main.push_back(b);
        fork
            host_main.send(b);
            begin
                repeat (200) @(negedge sys_clk_i);
                host_aux.send(~b);
            end
            put(b, 2'h1);
        join
        wait_idle();
        set_aux(1'h1, 1'h0, 1'h1);
        exp_aux.push_back(8'h0D);
        host_aux.send(8'h0D);
        wait_idle();
        set_aux(1'h1, 1'h0, 1'h0);
        host_aux.send(8'h41);
        repeat (1000) @(negedge sys_clk_i);
        $display("receive test done");
        // no drain: 512 characters would take far longer than the run allows
        main_rts = 1'h1;
        fmt = {2'h0, 1'h1, 1'h1};
        pulse(fmt_wr);
        msg = {8'h55, 2'h1};
        msg_valid = 1'h1;
        repeat (511) @(negedge sys_clk_i);
        msg_valid = 1'h0;
        @(negedge sys_clk_i);
        check(16'(fifo_full), 16'h0000);
        pulse(msg_valid);
        pulse(msg_valid);
        @(negedge sys_clk_i);
        check(16'({stall, fifo_full}), 16'h0001);
        do_reset();
        check(16'({main_txd, stall, fifo_full}), 16'h0008);
        k = 0;
        msg_valid = 1'h1;
        repeat (600) begin
            if (stall === 1'h0) k++;
            @(negedge sys_clk_i);
        end
        msg_valid = 1'h0;
        check(16'({stall, k >= 510 && k <= 512}), 16'h0003);
        $display("buffer test done");
        print_verdict();
    end
endmodule
